// ### src/dpr_top.sv
// Dual-port RAM with clear selection, read-during-write and APB setup
//
// What this block does
// - Optional asynchronous clear of registered ports
// - Clear reach chosen per register separately
// - Dual: outputs; single: read address, port B
// - Old-contents mode returns pre-write word
// - Don't-care mode may return any value
// - Don't-care enables unchecked collision flag
// - Port A same-port: new or old data
// - Same-port choice only with two read/write ports
// - New data shows at the write edge
// - Masked bytes read unknown under new data
`timescale 1ns/10ps
`include "dpr_cfg.svh"
module dpr_top (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Asynchronous clear
    input  wire logic                aclr,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire dpr_pkg::dpr_paddr_t paddr,
    input  wire dpr_pkg::dpr_pdata_t pwdata,
    output dpr_pkg::dpr_pdata_t      prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Port A (write port in single mode)
    input  wire dpr_pkg::dpr_addr_t  addrA,
    input  wire dpr_pkg::dpr_data_t  dinA,
    input  wire dpr_pkg::dpr_be_t    beA,
    input  wire logic                weA,
    output dpr_pkg::dpr_data_t       qA,
    // Port B (read port in single mode)
    input  wire dpr_pkg::dpr_addr_t  addrB,
    input  wire dpr_pkg::dpr_data_t  dinB,
    input  wire dpr_pkg::dpr_be_t    beB,
    input  wire logic                weB,
    output dpr_pkg::dpr_data_t       qB
);
    import dpr_pkg::*;

    // Clocked state without asynchronous clear
    typedef struct packed {
        dpr_pdata_t prdata;
        logic       pready;
        logic       pslverr;
        dpr_ctrl_t  ctrl;
        dpr_coll_t  coll;
        dpr_addr_t  addrA;
        dpr_data_t  dinA;
        dpr_be_t    beA;
        logic       weA;
        dpr_data_t  dinB;
        dpr_be_t    beB;
        logic       weB;
    } dpr_state_s;

    dpr_state_s st_q;
    dpr_state_s st_d;

    // Registers reached by the asynchronous clear
    dpr_addr_t  addrB_q;
    dpr_data_t  qA_q;
    dpr_data_t  qB_q;
    dpr_data_t  qA_d;
    dpr_data_t  qB_d;

    // Array and resolution signals
    dpr_data_t  memA;
    dpr_data_t  memB;
    dpr_data_t  resA;
    dpr_data_t  resB;
    logic       dual;
    logic       wrB;
    logic       sameA;
    logic       sameB;
    logic       mixA;
    logic       mixB;
    logic       clrAdr;
    logic       clrQa;
    logic       clrQb;
    logic       apbSetup;
    logic       apbDone;
    logic       hitCtrl;
    logic       hitStat;
    logic       hitColl;
    dpr_pdata_t statWord;

    // Mode decode and collision detection on the input registers
    assign dual  = st_q.ctrl[`DPR_C_DUAL];
    assign wrB   = st_q.weB & dual;
    assign sameA = st_q.weA & dual;
    assign sameB = wrB;
    assign mixA  = wrB && (addrB_q == st_q.addrA);
    assign mixB  = st_q.weA && (addrB_q == st_q.addrA);

    // Clear reach per register and per mode
    assign clrAdr = aclr & st_q.ctrl[`DPR_C_ACLREN]
                  & st_q.ctrl[`DPR_C_CLRADR] & ~dual;
    assign clrQa  = aclr & st_q.ctrl[`DPR_C_ACLREN]
                  & st_q.ctrl[`DPR_C_CLRQA] & dual;
    assign clrQb  = aclr & st_q.ctrl[`DPR_C_ACLREN]
                  & st_q.ctrl[`DPR_C_CLRQB];

    // Storage array, written from the input registers
    dpr_mem uMem (
        .core_clk (core_clk),
        .weA      (st_q.weA),
        .addrA    (st_q.addrA),
        .dinA     (st_q.dinA),
        .beA      (st_q.beA),
        .weB      (wrB),
        .addrB    (addrB_q),
        .dinB     (st_q.dinB),
        .beB      (st_q.beB),
        .rdA      (memA),
        .rdB      (memB)
    );

    // Port A output resolution
    dpr_rdw uRdwA (
        .memVal      (memA),
        .sameHit     (sameA),
        .sameNew     (st_q.ctrl[`DPR_C_ANEW]),
        .ownDin      (st_q.dinA),
        .ownBe       (st_q.beA),
        .mixHit      (mixA),
        .mixDontCare (st_q.ctrl[`DPR_C_MIXDC]),
        .val         (resA)
    );

    // Port B output resolution
    dpr_rdw uRdwB (
        .memVal      (memB),
        .sameHit     (sameB),
        .sameNew     (st_q.ctrl[`DPR_C_BNEW]),
        .ownDin      (st_q.dinB),
        .ownBe       (st_q.beB),
        .mixHit      (mixB),
        .mixDontCare (st_q.ctrl[`DPR_C_MIXDC]),
        .val         (resB)
    );

    // Output register inputs; old data is the stored word
    always_comb begin
        qA_d = dual ? resA : '0;
        qB_d = resB;
    end

    // APB phase and address decode
    assign apbSetup = psel & ~penable & ~st_q.pready;
    assign apbDone  = psel & penable & st_q.pready;
    assign hitCtrl  = (paddr == `DPR_OFF_CTRL);
    assign hitStat  = (paddr == `DPR_OFF_STAT);
    assign hitColl  = (paddr == `DPR_OFF_COLL);

    // Derived option flags seen by software
    always_comb begin
        statWord = '0;
        statWord[`DPR_S_NOCHK] = st_q.ctrl[`DPR_C_MIXDC];
        statWord[`DPR_S_XMASK] = st_q.ctrl[`DPR_C_ANEW]
                               | st_q.ctrl[`DPR_C_BNEW];
    end

    // Next state for bus, control, flags and input registers
    always_comb begin
        st_d = st_q;
        // Input registers take what user logic set up
        st_d.addrA = addrA;
        st_d.dinA  = dinA;
        st_d.beA   = beA;
        st_d.weA   = weA;
        st_d.dinB  = dinB;
        st_d.beB   = beB;
        st_d.weB   = weB;
        // One-cycle access phase
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
        if (apbSetup) begin
            st_d.pready  = 1'b1;
            st_d.pslverr = ~(hitCtrl | hitStat | hitColl);
            st_d.prdata  = '0;
            if (!pwrite && hitCtrl) begin
                st_d.prdata[`DPR_CTRL_W-1:0] = st_q.ctrl;
            end
            if (!pwrite && hitStat) begin
                st_d.prdata = statWord;
            end
            if (!pwrite && hitColl) begin
                st_d.prdata[`DPR_COLL_W-1:0] = st_q.coll;
            end
        end
        // Writes commit at the completing edge
        if (apbDone && pwrite && hitCtrl) begin
            st_d.ctrl = pwdata[`DPR_CTRL_W-1:0];
        end
        if (apbDone && pwrite && hitColl) begin
            st_d.coll = st_q.coll & ~pwdata[`DPR_COLL_W-1:0];
        end
        // Collision flags; a new event beats the clear
        if (mixA) begin
            st_d.coll[`DPR_F_MIXA] = 1'b1;
        end
        if (mixB) begin
            st_d.coll[`DPR_F_MIXB] = 1'b1;
        end
        if (sameA) begin
            st_d.coll[`DPR_F_SAMEA] = 1'b1;
        end
        if (sameB) begin
            st_d.coll[`DPR_F_SAMEB] = 1'b1;
        end
    end

    // Main state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q        <= '0;
            st_q.ctrl   <= `DPR_CTRL_RST;
            st_q.coll   <= `DPR_COLL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Read address register of port B
    always_ff @(posedge core_clk or posedge clrAdr) begin
        if (clrAdr) begin
            addrB_q <= '0;
        end else if (rst) begin
            addrB_q <= '0;
        end else begin
            addrB_q <= addrB;
        end
    end

    // Port A output register
    always_ff @(posedge core_clk or posedge clrQa) begin
        if (clrQa) begin
            qA_q <= '0;
        end else if (rst) begin
            qA_q <= '0;
        end else begin
            qA_q <= qA_d;
        end
    end

    // Port B output register
    always_ff @(posedge core_clk or posedge clrQb) begin
        if (clrQb) begin
            qB_q <= '0;
        end else if (rst) begin
            qB_q <= '0;
        end else begin
            qB_q <= qB_d;
        end
    end

    // Outputs straight from registers
    assign prdata  = st_q.prdata;
    assign pready  = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign qA      = qA_q;
    assign qB      = qB_q;
endmodule

// ### shared/dpr_cfg.svh
// Constants for the dual-port RAM block
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
// Array geometry
`define DPR_DW        16
`define DPR_AW        8
`define DPR_BW        2
`define DPR_LANE      8
`define DPR_DEPTH     256
// Register bus
`define DPR_PAW       12
`define DPR_PDW       32
`define DPR_OFF_CTRL  12'h000
`define DPR_OFF_STAT  12'h004
`define DPR_OFF_COLL  12'h008
// Control register fields
`define DPR_CTRL_W    8
`define DPR_CTRL_RST  8'h00
`define DPR_C_ACLREN  0
`define DPR_C_DUAL    1
`define DPR_C_CLRADR  2
`define DPR_C_CLRQA   3
`define DPR_C_CLRQB   4
`define DPR_C_MIXDC   5
`define DPR_C_ANEW    6
`define DPR_C_BNEW    7
// Status register fields
`define DPR_S_NOCHK   0
`define DPR_S_XMASK   1
// Collision flag fields
`define DPR_COLL_W    4
`define DPR_COLL_RST  4'h0
`define DPR_F_MIXA    0
`define DPR_F_MIXB    1
`define DPR_F_SAMEA   2
`define DPR_F_SAMEB   3
`endif

// ### shared/dpr_pkg.sv
// Types shared by the dual-port RAM files
`include "dpr_cfg.svh"
package dpr_pkg;
    typedef logic [`DPR_DW-1:0]   dpr_data_t;
    typedef logic [`DPR_AW-1:0]   dpr_addr_t;
    typedef logic [`DPR_BW-1:0]   dpr_be_t;
    typedef logic [`DPR_PAW-1:0]  dpr_paddr_t;
    typedef logic [`DPR_PDW-1:0]  dpr_pdata_t;
    typedef logic [`DPR_CTRL_W-1:0] dpr_ctrl_t;
    typedef logic [`DPR_COLL_W-1:0] dpr_coll_t;
endpackage

// ### src/dpr_mem.sv
// Byte-lane storage array with two write ports and two reads
`timescale 1ns/10ps
`include "dpr_cfg.svh"
module dpr_mem (
    // Clock
    input  wire logic               core_clk,
    // Port A write
    input  wire logic               weA,
    input  wire dpr_pkg::dpr_addr_t addrA,
    input  wire dpr_pkg::dpr_data_t dinA,
    input  wire dpr_pkg::dpr_be_t   beA,
    // Port B write
    input  wire logic               weB,
    input  wire dpr_pkg::dpr_addr_t addrB,
    input  wire dpr_pkg::dpr_data_t dinB,
    input  wire dpr_pkg::dpr_be_t   beB,
    // Current contents at both addresses
    output dpr_pkg::dpr_data_t      rdA,
    output dpr_pkg::dpr_data_t      rdB
);
    import dpr_pkg::*;

    // One array per byte lane; port B written last so it wins a tie
    genvar i;
    generate
        for (i = 0; i < `DPR_BW; i++) begin : gLane
            logic [`DPR_LANE-1:0] lane [`DPR_DEPTH];
            always_ff @(posedge core_clk) begin
                if (weA && beA[i]) begin
                    lane[addrA] <= dinA[i*`DPR_LANE +: `DPR_LANE];
                end
                if (weB && beB[i]) begin
                    lane[addrB] <= dinB[i*`DPR_LANE +: `DPR_LANE];
                end
            end
            assign rdA[i*`DPR_LANE +: `DPR_LANE] = lane[addrA];
            assign rdB[i*`DPR_LANE +: `DPR_LANE] = lane[addrB];
        end
    endgenerate
endmodule

// ### src/dpr_rdw.sv
// Read-during-write resolution for one read output
`timescale 1ns/10ps
`include "dpr_cfg.svh"
module dpr_rdw (
    // Stored word at the read address
    input  wire dpr_pkg::dpr_data_t memVal,
    // Own port write to the same word
    input  wire logic               sameHit,
    input  wire logic               sameNew,
    input  wire dpr_pkg::dpr_data_t ownDin,
    input  wire dpr_pkg::dpr_be_t   ownBe,
    // Other port write to the same word
    input  wire logic               mixHit,
    input  wire logic               mixDontCare,
    // Resolved value for the output register
    output dpr_pkg::dpr_data_t      val
);
    import dpr_pkg::*;

    dpr_data_t newVal;

    // New data per lane; masked lanes go unknown
    genvar i;
    generate
        for (i = 0; i < `DPR_BW; i++) begin : gLane
            assign newVal[i*`DPR_LANE +: `DPR_LANE] = ownBe[i] ?
                ownDin[i*`DPR_LANE +: `DPR_LANE] : {`DPR_LANE{1'bx}};
        end
    endgenerate

    // Same-port new data overrides the mixed-port result
    always_comb begin
        val = memVal;
        if (mixHit && mixDontCare) begin
            val = {`DPR_DW{1'bx}};
        end
        if (sameHit && sameNew) begin
            val = newVal;
        end
    end
endmodule

// ### tb/dpr_checker.sv
// Port assertions for the dual-port RAM top
`timescale 1ns/10ps
`include "dpr_cfg.svh"
module dpr_checker (
    // Clock, reset, clear
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               aclr,
    // APB
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic               pready,
    input wire dpr_pkg::dpr_paddr_t paddr,
    input wire dpr_pkg::dpr_pdata_t pwdata,
    input wire dpr_pkg::dpr_pdata_t prdata,
    // RAM ports
    input wire logic               weA,
    input wire logic               weB,
    input wire dpr_pkg::dpr_be_t   beA,
    input wire dpr_pkg::dpr_be_t   beB,
    input wire dpr_pkg::dpr_addr_t addrA,
    input wire dpr_pkg::dpr_addr_t addrB,
    input wire dpr_pkg::dpr_data_t dinA,
    input wire dpr_pkg::dpr_data_t dinB,
    input wire dpr_pkg::dpr_data_t qA,
    input wire dpr_pkg::dpr_data_t qB
);
    import dpr_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    dpr_ctrl_t ctl_q;
    logic      acc;
    // Control shadow from completed APB writes
    assign acc = psel && penable && pready;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctl_q <= '0;
        end else if (acc && pwrite && paddr == `DPR_OFF_CTRL) begin
            ctl_q <= pwdata[7:0];
        end
    end
    // Relations between controls and outputs
    a_stat_flags: assert property (
        acc && !pwrite && paddr == `DPR_OFF_STAT
        |-> prdata[1:0] == {ctl_q[6] | ctl_q[7], ctl_q[5]}) else $error("status flags wrong");
    a_clear_qb: assert property (
        aclr && ctl_q[0] && ctl_q[4] |-> qB == '0) else $error("qB not cleared");
    a_clear_qa: assert property (
        aclr && ctl_q[0] && ctl_q[1] && ctl_q[3] |-> qA == '0) else $error("qA not cleared");
    a_single_qa: assert property (
        !ctl_q[1] && !$past(ctl_q[1]) |-> qA == '0) else $error("qA live in single mode");
    a_new_a: assert property (
        ctl_q[1] && ctl_q[6] && !aclr && weA && beA == 2'h3
        |-> ##2 qA == $past(dinA, 2)) else $error("qA new data missing");
    a_new_b: assert property (
        ctl_q[1] && ctl_q[7] && !aclr && weB && beB == 2'h3
        |-> ##2 qB == $past(dinB, 2)) else $error("qB new data missing");
    a_old_a: assert property (
        ctl_q[1] && !ctl_q[6] && !aclr && weA && !weB && addrA == $past(addrA)
        && !$past(weA) && !$past(weB) |-> ##2 qA == $past(qA)) else $error("qA not old data");
    a_mixed_old: assert property (
        !ctl_q[1] && !ctl_q[5] && !aclr && weA && addrB == addrA && addrB == $past(addrB)
        && !$past(weA) |-> ##2 qB == $past(qB)) else $error("qB not old contents");
    // Main scenarios reached
    c_new_a: cover property (ctl_q[6] && weA);
    c_clear: cover property (aclr && ctl_q[0]);
    c_dontcare: cover property (acc && ctl_q[5]);
endmodule
bind dpr_top dpr_checker i_chk (
    .core_clk, .rst, .aclr, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .prdata,
    .weA, .weB, .beA, .beB, .addrA, .addrB, .dinA, .dinB, .qA, .qB
);

// ### tb/dpr_user_model.sv
// Fabric-side driver of both RAM ports
`timescale 1ns/10ps
module dpr_user_model (
    // Clock
    input wire logic          core_clk,
    // Port A
    output logic              weA,
    output dpr_pkg::dpr_addr_t addrA,
    output dpr_pkg::dpr_data_t dinA,
    output dpr_pkg::dpr_be_t  beA,
    // Port B
    output logic              weB,
    output dpr_pkg::dpr_addr_t addrB,
    output dpr_pkg::dpr_data_t dinB,
    output dpr_pkg::dpr_be_t  beB
);
    import dpr_pkg::*;
    // Idle at time zero
    initial begin
        {weA, addrA, dinA, beA} = '0;
        {weB, addrB, dinB, beB} = '0;
    end
    // One request cycle set up before its edge, then strobes drop
    task automatic put(input logic wa, input dpr_addr_t aa, input dpr_data_t da,
                       input dpr_be_t ba, input logic wb, input dpr_addr_t ab,
                       input dpr_data_t db, input dpr_be_t bb);
        @(posedge core_clk);
        {weA, addrA, dinA, beA} <= {wa, aa, da, ba};
        {weB, addrB, dinB, beB} <= {wb, ab, db, bb};
        @(posedge core_clk);
        weA  <= 1'b0;
        weB  <= 1'b0;
        dinA <= ~da; // Released data shows junk
        dinB <= ~db;
    endtask
endmodule

// ### tb/dpr_top_tb_top.sv
// Self-checking bench for the dual-port RAM top
`timescale 1ns/10ps
`include "dpr_cfg.svh"
module dpr_top_tb_top;
    import dpr_pkg::*;
    logic       core_clk, rst, aclr, psel, penable, pwrite, pready, pslverr, weA, weB, errv;
    dpr_paddr_t paddr;
    dpr_pdata_t pwdata, prdata, rdv;
    dpr_addr_t  addrA, addrB, ad;
    dpr_data_t  dinA, dinB, qA, qB, w0, w1, w2, w3;
    dpr_be_t    beA, beB;
    dpr_data_t  mem [int];
    int         errTotal, samplesChecked, cyc;
    dpr_user_model i_usr (.core_clk, .weA, .addrA, .dinA, .beA, .weB, .addrB, .dinB, .beB);
    dpr_top i_dut (.core_clk, .rst, .aclr, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .addrA, .dinA, .beA, .weA, .qA, .addrB, .dinB, .beB,
        .weB, .qB);
    // Clock and hang limit
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errTotal++;
            endSim();
        end
    end
    // Comparison, report and verdict
    task automatic chk(input string nm, input dpr_pdata_t seen, input dpr_pdata_t exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic endSim();
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // APB transfer held until pready
    task automatic apb(input logic w, input dpr_paddr_t a, input dpr_pdata_t d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1); // Only the cycle limit ends a hang
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Port request, then wait for its registered result
    task automatic go(input logic wa, input dpr_addr_t aa, input dpr_data_t da, input dpr_be_t ba,
                      input logic wb, input dpr_addr_t ab, input dpr_data_t db);
        i_usr.put(wa, aa, da, ba, wb, ab, db, 2'h3);
        @(posedge core_clk);
        @(negedge core_clk); // Result stands between edges
    endtask
    // Test sequence
    initial begin
        {rst, aclr, psel, penable, pwrite, paddr, pwdata} = {1'b1, 48'h0};
        void'($urandom(32'hCA9542B3));
        repeat (10) @(posedge core_clk);
        chk("qA", 32'(qA), 32'h0);
        chk("qB", 32'(qB), 32'h0);
        rst <= 1'b0;
        apb(1'b0, 12'h00C, 32'h0);
        chk("pslverr", 32'(errv), 32'h1);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            {ad, w0, w1} = 40'({$urandom, $urandom});
            ad[0] = 1'b1; // Keeps the first write away from unwritten word zero
            go(1'b1, ad, w0, 2'h3, 1'b0, ad, ~w0);
            mem[ad] = w0;
            go(1'b1, ad, w1, 2'h3, 1'b1, ad, ~w1);
            chk("qB", 32'(qB), 32'(mem[ad]));
            chk("qA", 32'(qA), 32'h0);
            mem[ad] = w1;
        end
        $display("test single done");
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `DPR_OFF_CTRL, m ? 32'hC2 : 32'h02);
            {ad, w0, w1, w2, w3} = 72'({$urandom, $urandom, $urandom});
            go(1'b1, ad, w0, 2'h3, 1'(m), ad ^ 8'h01, w2);
            go(1'b1, ad, w1, 2'h3, 1'(m), ad ^ 8'h01, w3);
            chk("qA", 32'(qA), 32'(m ? w1 : w0));
            if (m == 1) begin
                chk("qB", 32'(qB), 32'(w3));
                go(1'b1, ad, w2, 2'h1, 1'b0, ad ^ 8'h01, w2);
                chk("qA", 32'(qA), {16'h0, 8'hXX, w2[7:0]});
            end
            apb(1'b0, `DPR_OFF_STAT, 32'h0);
            chk("stat", rdv, m ? 32'h2 : 32'h0);
        end
        apb(1'b1, `DPR_OFF_CTRL, 32'h22);
        go(1'b1, ad, w0, 2'h3, 1'b0, ad, w0);
        apb(1'b0, `DPR_OFF_STAT, 32'h0);
        chk("stat", rdv, 32'h1);
        // Sticky flags: mixed hit on B, same-port writes on A and B
        apb(1'b0, `DPR_OFF_COLL, 32'h0);
        chk("coll", rdv, 32'hE);
        apb(1'b1, `DPR_OFF_COLL, 32'hF);
        apb(1'b0, `DPR_OFF_COLL, 32'h0);
        chk("coll", rdv, 32'h0);
        $display("test dual done");
        apb(1'b1, `DPR_OFF_CTRL, 32'h1B);
        go(1'b1, ad, w1, 2'h3, 1'b0, ad, w1);
        @(posedge core_clk);
        aclr <= 1'b1;
        @(posedge core_clk);
        chk("qA", 32'(qA), 32'h0);
        chk("qB", 32'(qB), 32'h0);
        apb(1'b1, `DPR_OFF_CTRL, 32'h13);
        repeat (2) @(posedge core_clk);
        chk("qA", 32'(qA), 32'(w1));
        chk("qB", 32'(qB), 32'h0);
        aclr <= 1'b0;
        $display("test clear done");
        endSim();
    end
endmodule
